/* design/burst_counter.v */
// per-port burst address counter with clear, load, hold and increment
`timescale 1ns/10ps
`default_nettype none
`include "dpram_defines.vh"
module burst_counter #(
   parameter AW = `ADDR_WIDTH
) (
   input  wire          clk,
   input  wire          rst_b,
   input  wire [AW-1:0] ext_addr,
   input  wire          addr_load_strobe_n,
   input  wire          burst_advance_n,
   input  wire          burst_clear_n,
   output wire [AW-1:0] access_addr
);
   reg [AW-1:0] count_reg;
   reg [AW-1:0] count_next;

   // clear beats load beats advance; chip selects play no part
   always @* begin
      if (!burst_clear_n) begin
         count_next = {AW{1'b0}};
      end else if (!addr_load_strobe_n) begin
         count_next = ext_addr;
      end else if (!burst_advance_n) begin
         count_next = count_reg + {{(AW-1){1'b0}}, 1'b1};
      end else begin
         count_next = count_reg;
      end
   end

   // counter runs whatever the selects do
   always @(posedge clk) begin
      if (!rst_b) begin
         count_reg <= {AW{1'b0}};
      end else begin
         count_reg <= count_next;
      end
   end

   // address used this cycle is the value latched at the edge
   assign access_addr = count_reg;
endmodule
`default_nettype wire

/* design/dpram_defines.vh */
// constants for the synchronous dual-port ram with burst counters
`ifndef DPRAM_DEFINES_VH
`define DPRAM_DEFINES_VH
`define ADDR_WIDTH      17
`define DATA_WIDTH      9
`define BURST_ZERO      17'h00000
`define CLK_PERIOD_NS   40
`define WRITE_TO_READ_DELAY_NS 30
`define CLOCK_SKEW_WINDOW_NS   9
`define FLOW_ACCESS_TIME_NS    15
// write-to-read delay in whole cycles, rounded up, at least one
`define WRITE_TO_READ_CYCLES \
   (((`WRITE_TO_READ_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
    ((`WRITE_TO_READ_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`endif

/* design/dual_port_sync_ram.v */
// top: true dual-port synchronous ram with burst counters on both ports
//
// Contract
// - inputs sampled at own clock edge; output enable acts combinationally.
// - deselect at an edge floats the data pins after that edge.
// - load strobe low captures the external address every edge; the code lets clear low override it.
// - cross-port write then flow read is valid after the write-to-read delay.
// - collision timing identical for either write direction.
// - driver state set by controls registered the cycle before.
// - host should rewrite location after a no-operation cycle.
// - access address is pins when loading, else counter output.
// - counter clear adds no idle cycle; access proceeds.
// - pipelined select change acts one clock later.
// - pipelined read data one cycle after flow-through.
// - counter works regardless of chip selects.
// - clear low sets counter to zero, access location zero.
// - load loads external address and uses it, advance ignored.
// - all high holds counter and re-accesses previous address.
// - advance low increments counter, next location accessed.
// - latency select low means flow-through, high pipelined.
`timescale 1ns/10ps
`default_nettype none
`include "dpram_defines.vh"
module dual_port_sync_ram #(
   parameter AW = `ADDR_WIDTH,
   parameter DW = `DATA_WIDTH
) (
   input  wire          CLK,
   input  wire          RST_B,
   input  wire          A_CHIP_SELECT_LOW_N,
   input  wire          A_CHIP_SELECT_HIGH,
   input  wire          A_WRITE_SELECT_N,
   input  wire          A_OUTPUT_ENABLE_N,
   input  wire          A_LATENCY_SELECT,
   input  wire          A_ADDR_LOAD_STROBE_N,
   input  wire          A_BURST_ADVANCE_N,
   input  wire          A_BURST_CLEAR_N,
   input  wire [AW-1:0] A_ADDR,
   input  wire [DW-1:0] A_DATA_IN,
   output wire [DW-1:0] A_DATA_OUT,
   output wire          A_DATA_OE,
   output wire          A_DATA_VALID,
   input  wire          B_CHIP_SELECT_LOW_N,
   input  wire          B_CHIP_SELECT_HIGH,
   input  wire          B_WRITE_SELECT_N,
   input  wire          B_OUTPUT_ENABLE_N,
   input  wire          B_LATENCY_SELECT,
   input  wire          B_ADDR_LOAD_STROBE_N,
   input  wire          B_BURST_ADVANCE_N,
   input  wire          B_BURST_CLEAR_N,
   input  wire [AW-1:0] B_ADDR,
   input  wire [DW-1:0] B_DATA_IN,
   output wire [DW-1:0] B_DATA_OUT,
   output wire          B_DATA_OE,
   output wire          B_DATA_VALID
);
   localparam WR_CYCLES = `WRITE_TO_READ_CYCLES;
   localparam DEPTH     = 1 << AW;

   reg  [DW-1:0] mem [0:DEPTH-1];
   wire [AW-1:0] a_addr;
   wire [AW-1:0] b_addr;
   wire          a_sel;
   wire          b_sel;
   wire          a_wr;
   wire          b_wr;
   wire [DW-1:0] a_wdata;
   wire [DW-1:0] b_wdata;
   wire [DW-1:0] a_rdata;
   wire [DW-1:0] b_rdata;
   reg  [3:0]    a_hazard_reg;
   reg  [3:0]    b_hazard_reg;
   reg           a_lat_reg;
   reg           b_lat_reg;
   wire          a_collide;
   wire          b_collide;
   wire [3:0]    a_window;
   wire [3:0]    b_window;

   // port a counter, independent of port b
   burst_counter #(.AW(AW)) a_counter (
      .clk                (CLK),
      .rst_b              (RST_B),
      .ext_addr           (A_ADDR),
      .addr_load_strobe_n (A_ADDR_LOAD_STROBE_N),
      .burst_advance_n    (A_BURST_ADVANCE_N),
      .burst_clear_n      (A_BURST_CLEAR_N),
      .access_addr        (a_addr)
   );

   // port b counter
   burst_counter #(.AW(AW)) b_counter (
      .clk                (CLK),
      .rst_b              (RST_B),
      .ext_addr           (B_ADDR),
      .addr_load_strobe_n (B_ADDR_LOAD_STROBE_N),
      .burst_advance_n    (B_BURST_ADVANCE_N),
      .burst_clear_n      (B_BURST_CLEAR_N),
      .access_addr        (b_addr)
   );

   // port a control and output path
   port_datapath #(.DW(DW)) a_path (
      .clk               (CLK),
      .rst_b             (RST_B),
      .chip_select_low_n (A_CHIP_SELECT_LOW_N),
      .chip_select_high  (A_CHIP_SELECT_HIGH),
      .write_select_n    (A_WRITE_SELECT_N),
      .latency_select    (A_LATENCY_SELECT),
      .output_enable_n   (A_OUTPUT_ENABLE_N),
      .din               (A_DATA_IN),
      .array_rdata       (a_rdata),
      .sel_reg_o         (a_sel),
      .wr_reg_o          (a_wr),
      .wdata_reg_o       (a_wdata),
      .dout              (A_DATA_OUT),
      .doe               (A_DATA_OE)
   );

   // port b control and output path
   port_datapath #(.DW(DW)) b_path (
      .clk               (CLK),
      .rst_b             (RST_B),
      .chip_select_low_n (B_CHIP_SELECT_LOW_N),
      .chip_select_high  (B_CHIP_SELECT_HIGH),
      .write_select_n    (B_WRITE_SELECT_N),
      .latency_select    (B_LATENCY_SELECT),
      .output_enable_n   (B_OUTPUT_ENABLE_N),
      .din               (B_DATA_IN),
      .array_rdata       (b_rdata),
      .sel_reg_o         (b_sel),
      .wr_reg_o          (b_wr),
      .wdata_reg_o       (b_wdata),
      .dout              (B_DATA_OUT),
      .doe               (B_DATA_OE)
   );

   // array writes; a same-address double write keeps port a's data
   always @(posedge CLK) begin
      if (a_sel && a_wr) begin
         mem[a_addr] <= a_wdata;
      end
      if (b_sel && b_wr && !(a_sel && a_wr && a_addr == b_addr)) begin
         mem[b_addr] <= b_wdata;
      end
   end

   // flow read sees the array as it stands; write lands at the next edge
   assign a_rdata = mem[a_addr];
   assign b_rdata = mem[b_addr];

   // opposite-port write in flight to the address this port reads now
   assign a_collide = b_sel && b_wr && (a_addr == b_addr);
   assign b_collide = a_sel && a_wr && (a_addr == b_addr);

   // collision history; latency mode kept to pick the right window
   always @(posedge CLK) begin
      if (!RST_B) begin
         a_hazard_reg <= 4'h0;
         b_hazard_reg <= 4'h0;
         a_lat_reg    <= 1'b0;
         b_lat_reg    <= 1'b0;
      end else begin
         a_hazard_reg <= {a_hazard_reg[2:0], a_collide};
         b_hazard_reg <= {b_hazard_reg[2:0], b_collide};
         a_lat_reg    <= A_LATENCY_SELECT;
         b_lat_reg    <= B_LATENCY_SELECT;
      end
   end

   // flow data reads the array now, so the write in flight counts this cycle;
   // pipelined data was read a cycle earlier, so its window is one cycle older
   assign a_window = a_lat_reg ? a_hazard_reg : {a_hazard_reg[2:0], a_collide};
   assign b_window = b_lat_reg ? b_hazard_reg : {b_hazard_reg[2:0], b_collide};

   // same rule both ways; one clock so skew is zero, delay rounds to cycles
   assign A_DATA_VALID = A_DATA_OE &&
                         ((a_window & ((4'h1 << WR_CYCLES) - 4'h1)) == 4'h0);
   assign B_DATA_VALID = B_DATA_OE &&
                         ((b_window & ((4'h1 << WR_CYCLES) - 4'h1)) == 4'h0);
   // no-operation cycles are not corrupted here; is the host's concern
endmodule
`default_nettype wire

/* design/port_datapath.v */
// one port's registered controls, output pipeline and pin drive
`timescale 1ns/10ps
`default_nettype none
`include "dpram_defines.vh"
module port_datapath #(
   parameter DW = `DATA_WIDTH
) (
   input  wire          clk,
   input  wire          rst_b,
   input  wire          chip_select_low_n,
   input  wire          chip_select_high,
   input  wire          write_select_n,
   input  wire          latency_select,
   input  wire          output_enable_n,
   input  wire [DW-1:0] din,
   input  wire [DW-1:0] array_rdata,
   output wire          sel_reg_o,
   output wire          wr_reg_o,
   output wire [DW-1:0] wdata_reg_o,
   output wire [DW-1:0] dout,
   output wire          doe
);
   reg          sel_reg;
   reg          wr_reg;
   reg          pipe_reg;
   reg [DW-1:0] wdata_reg;
   reg          rd_pipe_reg;
   reg [DW-1:0] dout_pipe_reg;

   // all synchronous inputs taken at the rising edge
   always @(posedge clk) begin
      if (!rst_b) begin
         sel_reg   <= 1'b0;
         wr_reg    <= 1'b0;
         pipe_reg  <= 1'b0;
         wdata_reg <= {DW{1'h0}};
      end else begin
         sel_reg   <= !chip_select_low_n && chip_select_high;
         wr_reg    <= !write_select_n;
         pipe_reg  <= latency_select;
         wdata_reg <= din;
      end
   end

   // second stage: pipelined read lands one cycle later
   always @(posedge clk) begin
      if (!rst_b) begin
         rd_pipe_reg   <= 1'b0;
         dout_pipe_reg <= {DW{1'h0}};
      end else begin
         rd_pipe_reg   <= sel_reg && !wr_reg;
         dout_pipe_reg <= array_rdata;
      end
   end

   // drive state comes from controls of the previous cycle, or two cycles back when pipelined; oe acts at once
   assign doe = !output_enable_n &&
                (pipe_reg ? rd_pipe_reg : (sel_reg && !wr_reg));
   assign dout        = pipe_reg ? dout_pipe_reg : array_rdata;
   assign sel_reg_o   = sel_reg;
   assign wr_reg_o    = wr_reg;
   assign wdata_reg_o = wdata_reg;
endmodule
`default_nettype wire

/* dv/dual_port_sync_ram_chk.sv */
// pin-level assertions for the dual-port ram
`timescale 1ns/10ps
`default_nettype none
module dual_port_sync_ram_chk (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic A_CHIP_SELECT_LOW_N,
   input wire logic A_CHIP_SELECT_HIGH,
   input wire logic A_WRITE_SELECT_N,
   input wire logic A_OUTPUT_ENABLE_N,
   input wire logic A_LATENCY_SELECT,
   input wire logic A_DATA_OE,
   input wire logic A_DATA_VALID,
   input wire logic B_CHIP_SELECT_LOW_N,
   input wire logic B_CHIP_SELECT_HIGH,
   input wire logic B_LATENCY_SELECT,
   input wire logic B_DATA_OE
);
   // decoded selects, reads and mode
   wire logic sa = !A_CHIP_SELECT_LOW_N && A_CHIP_SELECT_HIGH;
   wire logic sb = !B_CHIP_SELECT_LOW_N && B_CHIP_SELECT_HIGH;
   wire logic rd = sa && A_WRITE_SELECT_N;
   wire logic lt = A_LATENCY_SELECT;
   wire logic oe = !A_OUTPUT_ENABLE_N;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   a_flow_desel: assert property (!sa && !lt |=> !A_DATA_OE) else $error("A drives");
   a_pipe_desel: assert property (!sa ##1 !sa && lt |=> !A_DATA_OE) else $error("A on");
   a_flow_read: assert property (rd && !lt |=> A_DATA_OE == oe) else $error("A flow");
   a_pipe_read: assert property (rd && lt ##1 lt |=> A_DATA_OE == oe) else $error("A pipe");
   a_pipe_start: assert property (!sa && lt ##1 rd && lt |=> !A_DATA_OE)
      else $error("A early");
   a_oe_async: assert property (!oe |-> !A_DATA_OE) else $error("A ignores enable");
   a_write_float: assert property (sa && !A_WRITE_SELECT_N && !lt |=> !A_DATA_OE)
      else $error("A drives on write");
   a_valid_gated: assert property (!A_DATA_OE |-> !A_DATA_VALID) else $error("A valid");
   a_port_apart: assert property (!sb && !B_LATENCY_SELECT |=> !B_DATA_OE)
      else $error("B drives");
   c_pipe_read: cover property (rd && lt ##2 A_DATA_OE);
   c_collision: cover property (A_DATA_OE && !A_DATA_VALID);
   c_oe_off: cover property (rd && !oe);
endmodule
`default_nettype wire

/* dv/host_b.sv */
// far-side host model on port B: one write per request
`timescale 1ns/10ps
`default_nettype none
module host_b (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [16:0] a_in,
   input  wire logic [8:0]  d_in,
   output logic             cs_n,
   output logic             we_n,
   output logic             oe_n,
   output logic             ads_n,
   output logic [16:0]      a,
   output logic [8:0]       d
);
   initial {cs_n, we_n, oe_n, ads_n, a, d} = {4'hF, 26'h0};
   // pins move at the falling edge so they stand over the rising one
   always @(negedge clk) begin
      cs_n <= !go;
      we_n <= !go;
      oe_n <= 1'b1;
      ads_n <= 1'b0;
      a <= go ? a_in : ~a;
      d <= go ? d_in : ~d; // released bus toggles, stale data never matches
   end
endmodule
`default_nettype wire

/* dv/tb_dual_port_sync_ram.sv */
// self-checking bench: port A driven here, port B by the host model
`timescale 1ns/10ps
`default_nettype none
module tb_dual_port_sync_ram;
   localparam logic [5:0] RD = 6'h1B; // {csn,csh,wen,adsn,advn,clrn}
   localparam logic [5:0] WR = 6'h13;
   localparam logic [5:0] ID = 6'h3B;
   logic        CLK = 0, RST_B = 0, oen = 0, lat = 0, skip = 0, bgo = 0;
   logic [5:0]  c = ID;
   logic [16:0] ad = 0, cnt = 0, ba = 0, bad;
   logic [8:0]  di = 0, bd = 0, bdd, ado;
   logic        bcs, bwe, boe, bads, aoe, avld, bdoe, bvld;
   logic [8:0]  mem [int];
   logic [8:0]  q [$];
   int          error_cnt = 0, n_compared = 0, cyc = 0, m, i;
   always #20 CLK = ~CLK;
   dual_port_sync_ram uut (.CLK(CLK), .RST_B(RST_B),
      .A_CHIP_SELECT_LOW_N(c[5]), .A_CHIP_SELECT_HIGH(c[4]), .A_WRITE_SELECT_N(c[3]),
      .A_OUTPUT_ENABLE_N(oen), .A_LATENCY_SELECT(lat), .A_ADDR_LOAD_STROBE_N(c[2]),
      .A_BURST_ADVANCE_N(c[1]), .A_BURST_CLEAR_N(c[0]), .A_ADDR(ad), .A_DATA_IN(di),
      .A_DATA_OUT(ado), .A_DATA_OE(aoe), .A_DATA_VALID(avld),
      .B_CHIP_SELECT_LOW_N(bcs), .B_CHIP_SELECT_HIGH(1'b1), .B_WRITE_SELECT_N(bwe),
      .B_OUTPUT_ENABLE_N(boe), .B_LATENCY_SELECT(1'b0), .B_ADDR_LOAD_STROBE_N(bads),
      .B_BURST_ADVANCE_N(1'b1), .B_BURST_CLEAR_N(1'b1), .B_ADDR(bad), .B_DATA_IN(bdd),
      .B_DATA_OUT(), .B_DATA_OE(bdoe), .B_DATA_VALID(bvld));
   host_b hb (.clk(CLK), .go(bgo), .a_in(ba), .d_in(bd), .cs_n(bcs), .we_n(bwe),
      .oe_n(boe), .ads_n(bads), .a(bad), .d(bdd));
   task end_sim;
      begin
         if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // one port A cycle; the bench counter mirrors the burst counter
   task op(input logic [5:0] k, input logic [16:0] x, input logic [8:0] v);
      begin
         c = k;
         ad = x;
         di = v;
         if (!k[0]) cnt = 0;
         else if (!k[2]) cnt = x;
         else if (!k[1]) cnt = cnt + 1;
         if (!k[5] && k[4] && !k[3]) mem[cnt] = v;
         if (!k[5] && k[4] && k[3] && !oen && !skip) q.push_back(mem[cnt]);
         @(negedge CLK);
      end
   endtask
   // read words leave in issue order; a flagged collision word has no note
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (aoe === 1'b1 && avld !== 1'b0) begin
         n_compared++;
         if (q.size() == 0 || ado !== q[0]) begin
            error_cnt++;
            $display("unexpected A_DATA_OUT exp %h got %h", q.size() ? q[0] : 9'h1FF, ado);
         end
         if (q.size()) q.delete(0);
      end
      // host B keeps its output enable high, so its pins never drive
      if (bdoe !== 1'b0 || bvld !== 1'b0) begin
         error_cnt++;
         $display("unexpected B_DATA_OE exp 0 got %b", bdoe);
      end
      if (cyc == 3000) begin
         error_cnt++;
         end_sim;
      end
   end
   initial begin
      void'($urandom(32'h146B));
      repeat (2) @(posedge CLK);
      @(negedge CLK);
      RST_B = 1;
      op(ID, 0, 0);
      for (i = 0; i < 6; i++) op(WR, i, 9'($urandom));
      op(WR, 17'h1FFFF, 9'($urandom));
      for (m = 0; m < 2; m++) begin
         lat = m[0];
         op(ID, 0, 0);
         for (i = 5; i >= 0; i--) op(RD, i, 0);
         op(RD, 2, 0);
         op(6'h1D, 17'($urandom), 0);
         op(6'h1F, 17'($urandom), 0);
         op(6'h3D, 0, 0);
         op(6'h1F, 0, 0);
         op(6'h16, 17'h01234, 9'($urandom));
         op(6'h18, 5, 0);
         op(RD, 17'h1FFFF, 0);
         op(6'h1D, 0, 0);
         op(ID, 0, 0);
         op(ID, 0, 0);
         oen = 1;
         op(RD, 1, 0);
         op(ID, 0, 0);
         op(ID, 0, 0);
         oen = 0;
      end
      lat = 0;
      bd <= 9'($urandom);
      ba <= 17'h00100;
      bgo <= 1;
      op(ID, 0, 0);
      bgo <= 0;
      // read taken at the same edge as B's write: flagged, so no note
      skip = 1;
      op(RD, 17'h00100, 0);
      skip = 0;
      mem[17'h00100] = bd;
      op(RD, 17'h00100, 0);
      op(ID, 0, 0);
      op(RD, 17'h00100, 0);
      op(ID, 0, 0);
      op(ID, 0, 0);
      n_compared++;
      if (q.size() != 0) begin
         error_cnt++;
         $display("unexpected pending reads exp 0 got %0d", q.size());
      end
      end_sim;
   end
endmodule
bind dual_port_sync_ram dual_port_sync_ram_chk chk (.*);
`default_nettype wire
